// File: include/sso_pkg.sv
// Constants, register map and types for the step sequence output block.
// Contract
// - Mode-select low selects cumulative stepping (mode 1).
// - Mode-select high selects preset-pattern shifting (mode 2).
// - In mode 1 outputs one to seven advance on trigger rising edges, ascending.
// - In mode 1 each trigger turns on exactly one more selected output.
// - In mode 1, with all selected outputs on, next trigger clears all but output zero, restarting.
// - Output zero is on whenever no reset is active, independent of trigger, not configurable.
// - In mode 2 each output has a presettable value of zero or one.
// - In mode 2 the first trigger drives the stored preset pattern out.
// - In mode 2 each later trigger shifts the pattern one place right, cyclically.
// - An active reset input forces all eight outputs off.
// - Outputs three to seven are optional; outputs zero to two are always present.
// - Selecting an optional output also selects every lower output.
`default_nettype none

package sso_pkg;

	// ------------------------------------------------------------------
	// Widths.
	// ------------------------------------------------------------------
	localparam int SSO_OUT_W  = 8;
	localparam int SSO_IDX_W  = 3;
	localparam int SSO_ADDR_W = 4;
	localparam int SSO_DATA_W = 32;
	localparam int SSO_SYNC_W = 3;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses, one word each).
	// ------------------------------------------------------------------
	localparam logic [SSO_ADDR_W-1:0] SSO_CTRL_OFS   = 4'h0;
	localparam logic [SSO_ADDR_W-1:0] SSO_PRESET_OFS = 4'h4;
	localparam logic [SSO_ADDR_W-1:0] SSO_STATUS_OFS = 4'h8;

	// ------------------------------------------------------------------
	// Field values and reset values.
	// ------------------------------------------------------------------
	localparam logic [SSO_IDX_W-1:0] SSO_TOP_MIN    = 3'h2;
	localparam logic [SSO_IDX_W-1:0] SSO_TOP_MAX    = 3'h7;
	localparam logic [SSO_IDX_W-1:0] SSO_TOP_RST    = 3'h7;
	localparam logic [SSO_IDX_W-1:0] SSO_STEP_RST   = 3'h0;
	localparam logic [SSO_OUT_W-1:0] SSO_PRESET_RST = 8'h01;
	localparam logic [SSO_OUT_W-1:0] SSO_OUT_OFF    = 8'h00;
	localparam logic [SSO_OUT_W-1:0] SSO_OUT0_BIT   = 8'h01;

	// Bit positions in the synchroniser bundle.
	localparam int SSO_SYNC_TRG  = 0;
	localparam int SSO_SYNC_MODE = 1;
	localparam int SSO_SYNC_RST  = 2;

	// Status word field positions.
	localparam int SSO_ST_MODE_BIT  = 8;
	localparam int SSO_ST_PHASE_BIT = 9;
	localparam int SSO_ST_STEP_LSB  = 12;

	// Mode 2 progress: waiting for the first trigger, or shifting.
	typedef enum logic [0:0] {
		SSO_ARMED    = 1'b0,
		SSO_SHIFTING = 1'b1
	} sso_phase_t;

endpackage : sso_pkg

`default_nettype wire

// File: include/sso_sync_if.sv
// Bundle of raw inputs with their synchronised levels and rising edges.
`default_nettype none

interface sso_sync_if #(
	parameter int W = 3
);
	logic [W-1:0] async_in;	// Raw inputs from outside the clock domain.
	logic [W-1:0] level;	// Synchronised levels.
	logic [W-1:0] rise;	// One-cycle rising-edge pulses.

	modport sync (input async_in, output level, output rise);
	modport user (output async_in, input level, input rise);
endinterface : sso_sync_if

`default_nettype wire

// File: hdl/sso_sync.sv
// Two-flop synchroniser with a rising-edge detector for each bit.
`default_nettype none

module sso_sync #(
	parameter int W = 3
) (
	input  wire logic core_clk,	// Block clock.
	input  wire logic rst,		// Asynchronous reset, active high.
	sso_sync_if.sync  sig		// Raw inputs in, level and edge out.
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] stable_reg;
	logic [W-1:0] last_reg;

	// Two flops; only the second one is read by logic.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_reg   <= '0;
			stable_reg <= '0;
		end else begin
			meta_reg   <= sig.async_in;
			stable_reg <= meta_reg;
		end
	end

	// Delayed copy of the stable level for edge detection.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			last_reg <= '0;
		end else begin
			last_reg <= stable_reg;
		end
	end

	// Level and edge outputs.
	assign sig.level = stable_reg;
	assign sig.rise  = stable_reg & ~last_reg;
endmodule : sso_sync

`default_nettype wire

// File: hdl/sso_step_sequencer.sv
// Step sequencer with eight outputs, two modes and a small register port.
//
// Strobed register access and the placing of the registers were decided locally.
`default_nettype none

module sso_step_sequencer #(
	parameter int OUT_W = sso_pkg::SSO_OUT_W
) (
	input  wire logic                        core_clk,	// Block clock, 20 MHz.
	input  wire logic                        rst,		// Asynchronous reset, active high.
	input  wire logic                        trg_in,	// Trigger input.
	input  wire logic                        mode_in,	// Mode select: 0 stepping, 1 shifting.
	input  wire logic                        seq_rst_in,	// Sequencer reset input.
	input  wire logic [sso_pkg::SSO_ADDR_W-1:0] addr,	// Register address.
	input  wire logic [sso_pkg::SSO_DATA_W-1:0] wdata,	// Register write data.
	input  wire logic                        wr,		// Write strobe.
	input  wire logic                        rd,		// Read strobe.
	output var  logic [sso_pkg::SSO_DATA_W-1:0] rdata,	// Read data, cycle after rd.
	output var  logic [OUT_W-1:0]             step_out	// Sequencer outputs.
);
	// ------------------------------------------------------------------
	// Input synchronisation.
	// ------------------------------------------------------------------
	sso_sync_if #(.W(sso_pkg::SSO_SYNC_W)) sync_bus ();

	assign sync_bus.async_in = {seq_rst_in, mode_in, trg_in};

	sso_sync #(
		.W(sso_pkg::SSO_SYNC_W)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.sig      (sync_bus)
	);

	logic trg_rise;
	logic mode_lvl;
	logic hold_lvl;

	assign trg_rise = sync_bus.rise[sso_pkg::SSO_SYNC_TRG];
	assign mode_lvl = sync_bus.level[sso_pkg::SSO_SYNC_MODE];
	assign hold_lvl = sync_bus.level[sso_pkg::SSO_SYNC_RST];

	// ------------------------------------------------------------------
	// Configuration registers.
	// ------------------------------------------------------------------
	logic [sso_pkg::SSO_IDX_W-1:0] top_reg;
	logic [OUT_W-1:0]              preset_reg;
	logic [OUT_W-1:0]              sel_mask;
	logic [sso_pkg::SSO_IDX_W-1:0] top_wr;

	assign top_wr = wdata[sso_pkg::SSO_IDX_W-1:0];

	// Highest selected output; outputs zero to two are always selected.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			top_reg <= sso_pkg::SSO_TOP_RST;
		end else if (wr && addr == sso_pkg::SSO_CTRL_OFS) begin
			top_reg <= (top_wr < sso_pkg::SSO_TOP_MIN) ? sso_pkg::SSO_TOP_MIN : top_wr;
		end
	end

	// Preset pattern, one bit per output.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			preset_reg <= sso_pkg::SSO_PRESET_RST;
		end else if (wr && addr == sso_pkg::SSO_PRESET_OFS) begin
			preset_reg <= wdata[OUT_W-1:0];
		end
	end

	// Contiguous selection mask from output zero up to the top output.
	always_comb begin
		for (int i = 0; i < OUT_W; i++) begin
			sel_mask[i] = (i <= int'(top_reg));
		end
	end

	// ------------------------------------------------------------------
	// Sequencer state.
	// ------------------------------------------------------------------
	logic [sso_pkg::SSO_IDX_W-1:0] step_reg;
	logic [sso_pkg::SSO_IDX_W-1:0] step_next;
	logic [OUT_W-1:0]              pat_reg;
	logic [OUT_W-1:0]              pat_next;
	logic [OUT_W-1:0]              pat_rot;
	sso_pkg::sso_phase_t           phase_reg;
	sso_pkg::sso_phase_t           phase_next;
	logic                          mode_last_reg;
	logic                          mode_change;

	assign mode_change = (mode_lvl != mode_last_reg);

	// Previous mode, to restart the sequence when the mode changes.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_last_reg <= 1'b0;
		end else begin
			mode_last_reg <= mode_lvl;
		end
	end

	// Right rotation within the selected outputs: bit k moves to k+1.
	always_comb begin
		pat_rot = sso_pkg::SSO_OUT_OFF;
		for (int i = 1; i < OUT_W; i++) begin
			pat_rot[i] = pat_reg[i-1] & sel_mask[i];
		end
		pat_rot[0] = pat_reg[top_reg];
	end

	// Next-state logic for both modes.
	always_comb begin
		step_next  = step_reg;
		pat_next   = pat_reg;
		phase_next = phase_reg;
		if (hold_lvl || mode_change) begin
			step_next  = sso_pkg::SSO_STEP_RST;
			pat_next   = sso_pkg::SSO_OUT_OFF;
			phase_next = sso_pkg::SSO_ARMED;
		end else if (trg_rise) begin
			if (!mode_lvl) begin
				if (step_reg >= top_reg) begin
					step_next = sso_pkg::SSO_STEP_RST;
				end else begin
					step_next = step_reg + 3'h1;
				end
			end else begin
				unique case (phase_reg)
					sso_pkg::SSO_ARMED: begin
						pat_next   = preset_reg & sel_mask;
						phase_next = sso_pkg::SSO_SHIFTING;
					end
					sso_pkg::SSO_SHIFTING: begin
						pat_next = pat_rot;
					end
				endcase
			end
		end
	end

	// Step count for mode 1.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			step_reg <= sso_pkg::SSO_STEP_RST;
		end else begin
			step_reg <= step_next;
		end
	end

	// Pattern and phase for mode 2.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pat_reg   <= sso_pkg::SSO_OUT_OFF;
			phase_reg <= sso_pkg::SSO_ARMED;
		end else begin
			pat_reg   <= pat_next;
			phase_reg <= phase_next;
		end
	end

	// ------------------------------------------------------------------
	// Output stage.
	// ------------------------------------------------------------------
	logic [OUT_W-1:0] out_next;

	// Mode 1 lights outputs one to step; mode 2 shows the pattern.
	always_comb begin
		out_next = sso_pkg::SSO_OUT_OFF;
		if (!mode_lvl) begin
			for (int i = 1; i < OUT_W; i++) begin
				out_next[i] = (i <= int'(step_next));
			end
		end else begin
			out_next = pat_next;
		end
		out_next = out_next | sso_pkg::SSO_OUT0_BIT;
		if (hold_lvl) begin
			out_next = sso_pkg::SSO_OUT_OFF;
		end
	end

	// Registered outputs.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			step_out <= sso_pkg::SSO_OUT_OFF;
		end else begin
			step_out <= out_next;
		end
	end

	// ------------------------------------------------------------------
	// Register read port.
	// ------------------------------------------------------------------
	logic [sso_pkg::SSO_DATA_W-1:0] rd_word;

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_word = '0;
		unique case (addr)
			sso_pkg::SSO_CTRL_OFS: begin
				rd_word[sso_pkg::SSO_IDX_W-1:0] = top_reg;
			end
			sso_pkg::SSO_PRESET_OFS: begin
				rd_word[OUT_W-1:0] = preset_reg;
			end
			sso_pkg::SSO_STATUS_OFS: begin
				rd_word[OUT_W-1:0] = step_out;
				rd_word[sso_pkg::SSO_ST_MODE_BIT] = mode_lvl;
				rd_word[sso_pkg::SSO_ST_PHASE_BIT] = phase_reg;
				rd_word[sso_pkg::SSO_ST_STEP_LSB +: sso_pkg::SSO_IDX_W] = step_reg;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// Read data are valid only in the cycle after the read strobe.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (rd) begin
			rdata <= rd_word;
		end else begin
			rdata <= '0;
		end
	end
endmodule : sso_step_sequencer

`default_nettype wire

// File: verification/sso_step_sequencer_assertions.sv
// Port-level assertions for the step sequencer.
`default_nettype none

module sso_step_sequencer_assertions #(
	parameter int OUT_W = 8
) (
	input wire logic             core_clk,	// Block clock.
	input wire logic             rst,	// Reset, active high.
	input wire logic             trg_in,	// Trigger input.
	input wire logic             mode_in,	// Mode select.
	input wire logic             seq_rst_in,	// Sequencer reset.
	input wire logic [3:0]       addr,	// Register address.
	input wire logic [31:0]      wdata,	// Write data.
	input wire logic             wr,	// Write strobe.
	input wire logic             rd,	// Read strobe.
	input wire logic [31:0]      rdata,	// Read data.
	input wire logic [OUT_W-1:0] step_out	// Outputs.
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// A settled span with one mode and the sequencer reset low.
	sequence s_run(m);
		(mode_in == m && !seq_rst_in)[*5];
	endsequence

	a_bit0_on: assert property ((!seq_rst_in)[*4] |-> step_out[0])
		else $error("output zero is off");
	a_seq_clear: assert property (seq_rst_in[*3] |=> step_out == '0)
		else $error("sequencer reset left outputs on");
	a_rdata_idle: assert property (!rd |=> rdata == 32'h0000_0000)
		else $error("read data outside the read cycle");
	a_status_out: assert property (rd && addr == 4'h8 |=> rdata[7:0] == $past(step_out[7:0]))
		else $error("status does not show the outputs");
	a_unmapped_zero: assert property (rd && addr == 4'hC |=> rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_step_one: assert property (s_run(1'b0) ##0 $changed(step_out) |->
		step_out == {$past(step_out[6:0]), 1'b1} || step_out == 8'h01)
		else $error("stepping changed more than one output");
	a_trig_time: assert property (s_run(1'b0) ##0 $rose(trg_in) |-> ##[3:4] $changed(step_out))
		else $error("trigger did not advance the outputs");
	a_hold_idle: assert property ((!trg_in && !seq_rst_in && !mode_in)[*6] |-> $stable(step_out))
		else $error("outputs moved without a trigger");
	a_shift_right: assert property (s_run(1'b1) ##0 ($changed(step_out) && $past(step_out[7:1]) != 0)
		|-> (step_out[7:2] & ~$past(step_out[6:1])) == 6'h00 && step_out[0])
		else $error("pattern did not shift by one");
endmodule : sso_step_sequencer_assertions

bind sso_step_sequencer sso_step_sequencer_assertions #(.OUT_W(OUT_W)) u_sva (.core_clk, .rst,
	.trg_in, .mode_in, .seq_rst_in, .addr, .wdata, .wr, .rd, .rdata, .step_out);

`default_nettype wire

// File: verification/sso_far_end.sv
// Model of the function block that drives the trigger line.
`default_nettype none

module sso_far_end (
	input  wire logic core_clk,	// Block clock.
	input  wire logic fire,	// Request one trigger pulse.
	output wire logic trg_in	// Trigger line.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_reg = 3'h0;

	// Three cycles high then at least four low, so edges keep their spacing.
	always @(posedge core_clk) begin
		if (fire && cnt_reg == 3'h0) begin
			cnt_reg <= 3'h6;
		end else if (cnt_reg != 3'h0) begin
			cnt_reg <= cnt_reg - 3'h1;
		end
	end
	assign trg_in = (cnt_reg > 3'h3);
endmodule : sso_far_end

`default_nettype wire

// File: verification/sso_step_sequencer_bench.sv
// Self-checking bench for the step sequencer.
`default_nettype none

module sso_step_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk   = 1'b0;
	logic        rst        = 1'b1;
	logic        fire       = 1'b0;
	logic        mode_in    = 1'b0;
	logic        seq_rst_in = 1'b0;
	logic        wr         = 1'b0;
	logic        rd         = 1'b0;
	logic [3:0]  addr       = 4'h0;
	logic [31:0] wdata      = 32'h0000_0000;
	logic [7:0]  p;
	wire logic        trg_in;
	wire logic [31:0] rdata;
	wire logic [7:0]  step_out;
	int miscompares = 0;
	int tests_run = 0;

	sso_far_end u_sso_far_end (.core_clk(core_clk), .fire(fire), .trg_in(trg_in));
	sso_step_sequencer u_sso_step_sequencer (.core_clk(core_clk), .rst(rst), .trg_in(trg_in),
		.mode_in(mode_in), .seq_rst_in(seq_rst_in), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .step_out(step_out));

	// 20 MHz clock.
	initial begin
		forever #25 core_clk = ~core_clk;
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
		// One idle edge, so a following call never lowers and raises the strobe at once.
		@(posedge core_clk);
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		// Read data stand only in the cycle after the strobe; look mid-cycle.
		@(negedge core_clk);
		chk("rdata", e, rdata & m);
		@(posedge core_clk);
	endtask : rd_chk

	task automatic trig();
		fire <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask : trig

	task automatic out_chk(input logic [7:0] e);
		// Outputs settle after the rising edge; look mid-cycle, then realign.
		@(negedge core_clk);
		chk("step_out", {24'h0, e}, {24'h0, step_out});
		@(posedge core_clk);
	endtask : out_chk

	// Steps through a full cycle up to output k, then one more to clear.
	task automatic steps(input logic [2:0] k);
		logic [7:0] e;
		e = 8'h01;
		repeat (int'(k) + 1) begin
			trig();
			e = (e == (8'hFF >> (3'h7 - k))) ? 8'h01 : {e[6:0], 1'b1};
			out_chk(e);
			rd_chk(sso_pkg::SSO_STATUS_OFS, {24'h0, e}, 32'h0000_03FF);
		end
	endtask : steps

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	// Cuts a hang short.
	initial begin
		repeat (4000) @(posedge core_clk);
		miscompares++;
		give_verdict();
	end

	// Test sequence.
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		out_chk(8'h01);
		rd_chk(sso_pkg::SSO_CTRL_OFS, 32'h0000_0007, 32'hFFFF_FFFF);
		rd_chk(sso_pkg::SSO_PRESET_OFS, 32'h0000_0001, 32'hFFFF_FFFF);
		rd_chk(4'hC, 32'h0000_0000, 32'hFFFF_FFFF);
		$display("test reset done");
		steps(3'h7);
		wr_reg(sso_pkg::SSO_CTRL_OFS, 32'h0000_0003);
		steps(3'h3);
		wr_reg(sso_pkg::SSO_CTRL_OFS, 32'h0000_0000);
		rd_chk(sso_pkg::SSO_CTRL_OFS, 32'h0000_0002, 32'h0000_0007);
		steps(3'h2);
		wr_reg(sso_pkg::SSO_CTRL_OFS, 32'h0000_0007);
		$display("test stepping done");
		wr_reg(sso_pkg::SSO_PRESET_OFS, 32'h0000_0005);
		wr_reg(4'hC, 32'h0000_00FF);
		rd_chk(sso_pkg::SSO_PRESET_OFS, 32'h0000_0005, 32'h0000_00FF);
		mode_in <= 1'b1;
		repeat (5) @(posedge core_clk);
		out_chk(8'h01);
		p = 8'h05;
		repeat (9) begin
			trig();
			out_chk(p | 8'h01);
			rd_chk(sso_pkg::SSO_STATUS_OFS, {22'h0, 2'b11, p | 8'h01}, 32'h0000_03FF);
			p = {p[6:0], p[7]};
		end
		$display("test shifting done");
		// A one-cycle reset pulse lands in the same cycle as the trigger edge.
		fire <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
		seq_rst_in <= 1'b1;
		@(posedge core_clk);
		seq_rst_in <= 1'b0;
		repeat (8) @(posedge core_clk);
		out_chk(8'h01);
		trig();
		out_chk(8'h05);
		seq_rst_in <= 1'b1;
		trig();
		out_chk(8'h00);
		seq_rst_in <= 1'b0;
		repeat (4) @(posedge core_clk);
		out_chk(8'h01);
		trig();
		out_chk(8'h05);
		$display("test sequencer reset done");
		give_verdict();
	end
endmodule : sso_step_sequencer_bench

`default_nettype wire
